// ---- shared/ddcn_pkg.sv ----
package ddcn_pkg;

	// Channel and word sizes
	localparam int NUM_CH  = 16;
	localparam int CH_W    = 4;
	localparam int FREQ_W  = 24;
	localparam int POFS_W  = 48;
	localparam int PHASE_W = 48;
	localparam int IDX_W   = 12;
	localparam int ADDR_W  = 16;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_NCO_CTRL   = 12'h334;
	localparam logic [IDX_W-1:0] IDX_PHASE_CTRL = 12'h335;
	localparam logic [IDX_W-1:0] IDX_FREQ0      = 12'h336;
	localparam logic [IDX_W-1:0] IDX_FREQ1      = 12'h337;
	localparam logic [IDX_W-1:0] IDX_FREQ2      = 12'h338;
	localparam logic [IDX_W-1:0] IDX_POFS0      = 12'h33D;
	localparam logic [IDX_W-1:0] IDX_POFS5      = 12'h342;
	localparam logic [IDX_W-1:0] IDX_UPD_CTRL   = 12'h3F0;

	// Field positions
	localparam int MAP_SEL_LSB  = 0;
	localparam int UPD_IDX_LSB  = 0;
	localparam int UPD_MODE_BIT = 0;
	localparam int XFER_BIT     = 1;
	localparam int APPLIED_BIT  = 2;

	// Reset values
	localparam logic [7:0]       RST_BYTE  = 8'h00;
	localparam logic [FREQ_W-1:0]  RST_FREQ  = 24'h000000;
	localparam logic [POFS_W-1:0]  RST_POFS  = 48'h000000000000;
	localparam logic [PHASE_W-1:0] RST_PHASE = 48'h000000000000;

	typedef enum logic
	{
		UPD_CONTINUOUS,
		UPD_TRANSFER
	} ddcn_upd_mode_t;

	typedef enum logic [1:0]
	{
		BUS_IDLE,
		BUS_WRITE,
		BUS_READ_WAIT,
		BUS_READ_DONE
	} ddcn_bus_state_t;

	typedef struct packed
	{
		logic [FREQ_W-1:0] frequency_tuning_word;
		logic [POFS_W-1:0] phase_offset_word;
	} ddcn_chan_cfg_t;

	typedef struct packed
	{
		logic             write;
		logic [IDX_W-1:0] idx;
	} ddcn_addr_phase_t;

endpackage

// ---- rtl/ddcn_nco.sv ----
`timescale 1ns/1ps
module ddcn_nco
(
	// Clock and reset
	input  wire logic                            clock_i,
	input  wire logic                            rst_b_i,
	// Configuration and sample rate
	input  wire ddcn_pkg::ddcn_chan_cfg_t        cfg_i,
	input  wire logic                            sample_en_i,
	// Phase out
	output logic     [ddcn_pkg::PHASE_W-1:0]     phase_o
);

	logic [ddcn_pkg::PHASE_W-1:0] acc_q;
	logic [ddcn_pkg::PHASE_W-1:0] acc_d;
	logic [ddcn_pkg::PHASE_W-1:0] step;
	logic [ddcn_pkg::PHASE_W-1:0] phase_d;

	// Twos-complement step, one phase turn is two to the 48
	assign step = {{(ddcn_pkg::PHASE_W-ddcn_pkg::FREQ_W)
		{cfg_i.frequency_tuning_word[ddcn_pkg::FREQ_W-1]}},
		cfg_i.frequency_tuning_word};
	assign acc_d   = sample_en_i ? acc_q + step : acc_q;
	assign phase_d = acc_q + cfg_i.phase_offset_word;

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			acc_q   <= ddcn_pkg::RST_PHASE;
			phase_o <= ddcn_pkg::RST_PHASE;
		end
		else
		begin
			acc_q   <= acc_d;
			phase_o <= phase_d;
		end
	end

endmodule

// ---- rtl/ddcn_regs.sv ----
// What this block does
// - Four-bit read-write selector picks which channel set the map exposes.
// - Selector value n selects channel n, for channels zero to fifteen.
// - Four-bit read-write update index names the channel to refresh.
// - Indexed update applies continuously or only after a transfer request.
// - Update index codes zero to fifteen name channels zero to fifteen.
// - Tuning word is twos complement; frequency is word times rate over 2^48.
// - Tuning word low bytes sit in three consecutive read-write byte registers.
// - Phase offset is 48 bits over six byte registers, low byte first.
`timescale 1ns/1ps
module ddcn_regs
(
	// Clock and reset
	input  wire logic                            clock_i,
	input  wire logic                            rst_b_i,
	// AHB-Lite slave
	input  wire logic                            hsel_i,
	input  wire logic [ddcn_pkg::ADDR_W-1:0]     haddr_i,
	input  wire logic [1:0]                      htrans_i,
	input  wire logic                            hwrite_i,
	input  wire logic [2:0]                      hsize_i,
	input  wire logic                            hready_i,
	input  wire logic [31:0]                     hwdata_i,
	output logic      [31:0]                     hrdata_o,
	output logic                                 hreadyout_o,
	output logic                                 hresp_o,
	// Oscillator side
	input  wire logic [ddcn_pkg::CH_W-1:0]       nco_channel_i,
	input  wire logic                            sample_en_i,
	output ddcn_pkg::ddcn_chan_cfg_t             active_cfg_o,
	output logic      [ddcn_pkg::PHASE_W-1:0]    phase_o
);

	localparam int NCH = ddcn_pkg::NUM_CH;

	// Byte n of a wide word
	function automatic logic [7:0] get_byte(input logic [ddcn_pkg::POFS_W-1:0] w,
		input logic [2:0] n);
		logic [ddcn_pkg::POFS_W-1:0] s;
		s = w >> {n, 3'h0};
		return s[7:0];
	endfunction

	// Word with byte n replaced
	function automatic logic [ddcn_pkg::POFS_W-1:0] put_byte(
		input logic [ddcn_pkg::POFS_W-1:0] w, input logic [2:0] n, input logic [7:0] b);
		logic [ddcn_pkg::POFS_W-1:0] m;
		logic [ddcn_pkg::POFS_W-1:0] v;
		m = {{(ddcn_pkg::POFS_W-8){1'b0}}, 8'hFF} << {n, 3'h0};
		v = {{(ddcn_pkg::POFS_W-8){1'b0}}, b} << {n, 3'h0};
		return (w & ~m) | v;
	endfunction

	// Index inside an inclusive span
	function automatic logic in_span(input logic [ddcn_pkg::IDX_W-1:0] idx,
		input logic [ddcn_pkg::IDX_W-1:0] lo, input logic [ddcn_pkg::IDX_W-1:0] hi);
		return (idx >= lo) && (idx <= hi);
	endfunction

	// Byte lane of an index counted from a base
	function automatic logic [2:0] lane_of(input logic [ddcn_pkg::IDX_W-1:0] idx,
		input logic [ddcn_pkg::IDX_W-1:0] base);
		logic [ddcn_pkg::IDX_W-1:0] d;
		d = idx - base;
		return d[2:0];
	endfunction

	// Bus state
	ddcn_pkg::ddcn_bus_state_t  state_q;
	ddcn_pkg::ddcn_bus_state_t  state_d;
	ddcn_pkg::ddcn_addr_phase_t ap_q;
	logic [31:0]                hrdata_d;

	// Control registers
	logic [7:0]                  nco_ctrl_q;
	logic [ddcn_pkg::CH_W-1:0]   upd_idx_q;
	ddcn_pkg::ddcn_upd_mode_t    upd_mode_q;
	logic                        xfer_q;
	logic                        applied_q;

	// Per-channel written and active sets
	logic [ddcn_pkg::FREQ_W-1:0] freq_q [NCH];
	logic [ddcn_pkg::POFS_W-1:0] pofs_q [NCH];
	logic [ddcn_pkg::FREQ_W-1:0] act_freq_q [NCH];
	logic [ddcn_pkg::POFS_W-1:0] act_pofs_q [NCH];

	// Decode
	logic                        addr_ok;
	logic                        wr_en;
	logic [7:0]                  wbyte;
	logic [ddcn_pkg::CH_W-1:0]   map_sel;
	logic                        hit_nco_ctrl;
	logic                        hit_phase_ctrl;
	logic                        hit_freq;
	logic                        hit_pofs;
	logic                        hit_upd_ctrl;
	logic [2:0]                  freq_lane;
	logic [2:0]                  pofs_lane;
	logic [ddcn_pkg::POFS_W-1:0] freq_wide;
	logic [7:0]                  rd_freq;
	logic [7:0]                  rd_pofs;
	logic [7:0]                  rd_upd;
	logic [7:0]                  rd_byte;
	logic                        apply;
	logic                        xfer_set;
	logic                        applied_clr;
	logic                        xfer_d;
	logic                        applied_d;
	ddcn_pkg::ddcn_chan_cfg_t    sel_cfg;

	assign addr_ok = hsel_i & htrans_i[1] & hready_i;
	assign wr_en   = (state_q == ddcn_pkg::BUS_WRITE) & ap_q.write;
	assign wbyte   = hwdata_i[7:0];

	assign map_sel = nco_ctrl_q[ddcn_pkg::MAP_SEL_LSB +: ddcn_pkg::CH_W];

	assign freq_lane = lane_of(ap_q.idx, ddcn_pkg::IDX_FREQ0);
	assign pofs_lane = lane_of(ap_q.idx, ddcn_pkg::IDX_POFS0);

	assign hit_nco_ctrl   = (ap_q.idx == ddcn_pkg::IDX_NCO_CTRL);
	assign hit_phase_ctrl = (ap_q.idx == ddcn_pkg::IDX_PHASE_CTRL);
	assign hit_freq       = in_span(ap_q.idx, ddcn_pkg::IDX_FREQ0, ddcn_pkg::IDX_FREQ2);
	assign hit_pofs       = in_span(ap_q.idx, ddcn_pkg::IDX_POFS0, ddcn_pkg::IDX_POFS5);
	assign hit_upd_ctrl   = (ap_q.idx == ddcn_pkg::IDX_UPD_CTRL);

	assign freq_wide = {{(ddcn_pkg::POFS_W-ddcn_pkg::FREQ_W){1'b0}}, freq_q[map_sel]};
	assign rd_freq   = get_byte(freq_wide, freq_lane);
	assign rd_pofs   = get_byte(pofs_q[map_sel], pofs_lane);
	assign rd_upd    = {5'h00, applied_q, xfer_q, upd_mode_q};

	// Read selection, reserved and unmapped read as zero
	assign rd_byte =
		hit_nco_ctrl   ? nco_ctrl_q :
		hit_phase_ctrl ? {4'h0, upd_idx_q} :
		hit_freq       ? rd_freq :
		hit_pofs       ? rd_pofs :
		hit_upd_ctrl   ? rd_upd :
		8'h00;

	// Bus sequencing, reads take one wait state
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ddcn_pkg::BUS_IDLE,
			ddcn_pkg::BUS_WRITE,
			ddcn_pkg::BUS_READ_DONE:
			begin
				if (addr_ok)
				begin
					state_d = hwrite_i ? ddcn_pkg::BUS_WRITE : ddcn_pkg::BUS_READ_WAIT;
				end
				else
				begin
					state_d = ddcn_pkg::BUS_IDLE;
				end
			end
			ddcn_pkg::BUS_READ_WAIT:
			begin
				state_d = ddcn_pkg::BUS_READ_DONE;
			end
			default:
			begin
				state_d = ddcn_pkg::BUS_IDLE;
			end
		endcase
	end

	assign hrdata_d    = (state_q == ddcn_pkg::BUS_READ_WAIT) ? {24'h000000, rd_byte} : hrdata_o;
	assign hreadyout_o = (state_q != ddcn_pkg::BUS_READ_WAIT);
	assign hresp_o     = 1'b0;

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_q  <= ddcn_pkg::BUS_IDLE;
			ap_q     <= '0;
			hrdata_o <= 32'h00000000;
		end
		else
		begin
			state_q  <= state_d;
			hrdata_o <= hrdata_d;
			if (addr_ok)
			begin
				ap_q <= '{write: hwrite_i, idx: haddr_i[ddcn_pkg::IDX_W+1:2]};
			end
		end
	end

	// Control fields
	assign xfer_set    = wr_en & hit_upd_ctrl & wbyte[ddcn_pkg::XFER_BIT];
	assign applied_clr = wr_en & hit_upd_ctrl & wbyte[ddcn_pkg::APPLIED_BIT];
	assign apply       = (upd_mode_q == ddcn_pkg::UPD_CONTINUOUS) | xfer_q;
	// New request wins over the one being consumed
	assign xfer_d      = xfer_set | (xfer_q & ~apply);
	// Set wins over clear
	assign applied_d   = (xfer_q & apply) | (applied_q & ~applied_clr);

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			nco_ctrl_q <= ddcn_pkg::RST_BYTE;
			upd_idx_q  <= '0;
			upd_mode_q <= ddcn_pkg::UPD_CONTINUOUS;
			xfer_q     <= 1'b0;
			applied_q  <= 1'b0;
		end
		else
		begin
			if (wr_en && hit_nco_ctrl)
			begin
				nco_ctrl_q <= wbyte;
			end
			if (wr_en && hit_phase_ctrl)
			begin
				upd_idx_q <= wbyte[ddcn_pkg::UPD_IDX_LSB +: ddcn_pkg::CH_W];
			end
			if (wr_en && hit_upd_ctrl)
			begin
				upd_mode_q <= ddcn_pkg::ddcn_upd_mode_t'(wbyte[ddcn_pkg::UPD_MODE_BIT]);
			end
			xfer_q    <= xfer_d;
			applied_q <= applied_d;
		end
	end

	// Written sets, addressed through the map selector
	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			for (int i = 0; i < NCH; i++)
			begin
				freq_q[i] <= ddcn_pkg::RST_FREQ;
			end
		end
		else if (wr_en && hit_freq)
		begin
			freq_q[map_sel] <= ddcn_pkg::FREQ_W'(put_byte(freq_wide, freq_lane, wbyte));
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			for (int i = 0; i < NCH; i++)
			begin
				pofs_q[i] <= ddcn_pkg::RST_POFS;
			end
		end
		else if (wr_en && hit_pofs)
		begin
			pofs_q[map_sel] <= put_byte(pofs_q[map_sel], pofs_lane, wbyte);
		end
	end

	// Active sets, refreshed for the indexed channel only
	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			for (int i = 0; i < NCH; i++)
			begin
				act_freq_q[i] <= ddcn_pkg::RST_FREQ;
				act_pofs_q[i] <= ddcn_pkg::RST_POFS;
			end
		end
		else if (apply)
		begin
			act_freq_q[upd_idx_q] <= freq_q[upd_idx_q];
			act_pofs_q[upd_idx_q] <= pofs_q[upd_idx_q];
		end
	end

	// Active set of the channel the oscillator runs
	assign sel_cfg = '{frequency_tuning_word: act_freq_q[nco_channel_i],
		phase_offset_word: act_pofs_q[nco_channel_i]};

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			active_cfg_o <= '0;
		end
		else
		begin
			active_cfg_o <= sel_cfg;
		end
	end

	ddcn_nco u_nco
	(
		.clock_i     (clock_i),
		.rst_b_i     (rst_b_i),
		.cfg_i       (active_cfg_o),
		.sample_en_i (sample_en_i),
		.phase_o     (phase_o)
	);

endmodule

// ---- tb/ddcn_regs_assertions.sv ----
`timescale 1ns/1ps
module ddcn_regs_assertions
(
	// Clock and reset
	input wire logic                         clock_i,
	input wire logic                         rst_b_i,
	// Bus
	input wire logic                         hsel_i,
	input wire logic [ddcn_pkg::ADDR_W-1:0]  haddr_i,
	input wire logic [1:0]                   htrans_i,
	input wire logic                         hwrite_i,
	input wire logic                         hready_i,
	input wire logic [31:0]                  hrdata_o,
	input wire logic                         hreadyout_o,
	input wire logic                         hresp_o,
	// Oscillator
	input wire logic                         sample_en_i,
	input wire ddcn_pkg::ddcn_chan_cfg_t     active_cfg_o,
	input wire logic [ddcn_pkg::PHASE_W-1:0] phase_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_b_i);
	wire        tk = hsel_i && htrans_i[1] && hready_i;
	wire [11:0] ix = haddr_i[13:2];
	wire [23:0] fw = active_cfg_o.frequency_tuning_word;
	wire [47:0] fx = {{24{fw[23]}}, fw};
	read_wait_a: assert property (tk && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
		else $error("read wait state wrong");
	write_nowait_a: assert property (tk && hwrite_i |=> hreadyout_o)
		else $error("write stalled");
	okay_resp_a: assert property (hresp_o == 1'b0)
		else $error("response not OKAY");
	reserved_zero_a: assert property (tk && !hwrite_i && ix == ddcn_pkg::IDX_PHASE_CTRL
		|=> ##1 hrdata_o[7:4] == 4'h0) else $error("reserved bits not zero");
	hole_zero_a: assert property (tk && !hwrite_i && ix >= 12'h339 && ix <= 12'h33C
		|=> ##1 hrdata_o == 32'h0) else $error("unmapped read not zero");
	byte_wide_a: assert property (hrdata_o[31:8] == 24'h0)
		else $error("upper read bits set");
	rdata_hold_a: assert property (hreadyout_o && $past(hreadyout_o) |-> $stable(hrdata_o))
		else $error("read data moved");
	phase_hold_a: assert property ((!sample_en_i && $stable(active_cfg_o))[*3]
		|=> $stable(phase_o)) else $error("phase moved while idle");
	phase_step_a: assert property ((sample_en_i && $stable(active_cfg_o))[*3]
		|=> phase_o - $past(phase_o) == $past(fx)) else $error("phase step wrong");
endmodule
bind ddcn_regs ddcn_regs_assertions u_chk (.clock_i(clock_i), .rst_b_i(rst_b_i),
	.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
	.hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
	.hresp_o(hresp_o), .sample_en_i(sample_en_i), .active_cfg_o(active_cfg_o),
	.phase_o(phase_o));

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	logic        clock_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic        hsel_i = 1'b0;
	logic [15:0] haddr_i = 16'h0000;
	logic [1:0]  htrans_i = 2'h0;
	logic        hwrite_i = 1'b0;
	logic [31:0] hwdata_i = 32'h0;
	logic [3:0]  nco_channel_i = 4'h0;
	logic        sample_en_i = 1'b0;
	logic [31:0] hrdata_o;
	logic        hreadyout_o;
	logic        hresp_o;
	logic [47:0] phase_o;
	logic [47:0] p1;
	int          fail_count = 0;
	int          check_count = 0;
	ddcn_pkg::ddcn_chan_cfg_t active_cfg_o;
	localparam logic [11:0] RST_IDX [8] = '{12'h334, 12'h335, 12'h336, 12'h337,
		12'h338, 12'h33D, 12'h342, 12'h3F0};
	always #20 clock_i = ~clock_i;
	ddcn_regs uut (.clock_i(clock_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hready_i(hreadyout_o),
		.hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o), .nco_channel_i(nco_channel_i), .sample_en_i(sample_en_i),
		.active_cfg_o(active_cfg_o), .phase_o(phase_o));
	task automatic check(input logic [71:0] seen, input logic [71:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] ix, input logic [7:0] wd,
		output logic [31:0] r);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		hwrite_i <= w;
		haddr_i <= {2'h0, ix, 2'h0};
		@(posedge clock_i iff hreadyout_o);
		htrans_i <= 2'h0;
		hwdata_i <= {24'h0, wd};
		@(posedge clock_i iff hreadyout_o);
		r = hrdata_o;
	endtask
	task automatic wr(input logic [11:0] ix, input logic [7:0] d);
		logic [31:0] r;
		xfer(1'b1, ix, d, r);
	endtask
	task automatic rd(input logic [11:0] ix, input logic [7:0] e);
		logic [31:0] r;
		xfer(1'b0, ix, 8'h00, r);
		check(r, {24'h0, e});
	endtask
	task automatic cfg_chk(input logic [23:0] e);
		repeat (3) @(posedge clock_i);
		check(active_cfg_o.frequency_tuning_word, e);
	endtask
	task automatic wrap_up;
		if (fail_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		#200000;
		fail_count++;
		wrap_up();
	end
	initial
	begin
		repeat (2) @(posedge clock_i);
		rst_b_i <= 1'b1;
		@(posedge clock_i);
		foreach (RST_IDX[i]) rd(RST_IDX[i], 8'h00);
		wr(12'h339, 8'hAA);
		rd(12'h339, 8'h00);
		wr(12'h335, 8'hFF);
		rd(12'h335, 8'h0F);
		for (int c = 0; c < 16; c++)
		begin
			wr(12'h334, c[7:0]);
			for (int b = 0; b < 3; b++) wr(12'h336 + b[11:0], {c[3:0], b[3:0]});
		end
		for (int c = 0; c < 16; c++)
		begin
			wr(12'h334, c[7:0]);
			rd(12'h334, c[7:0]);
			for (int b = 0; b < 3; b++) rd(12'h336 + b[11:0], {c[3:0], b[3:0]});
		end
		for (int c = 0; c < 4; c++)
		begin
			nco_channel_i <= c[3:0];
			cfg_chk(24'h000000);
			wr(12'h335, c[7:0]);
			cfg_chk({c[3:0], 4'h2, c[3:0], 4'h1, c[3:0], 4'h0});
		end
		wr(12'h3F0, 8'h01);
		wr(12'h334, 8'h03);
		wr(12'h336, 8'h5A);
		cfg_chk(24'h323130);
		wr(12'h3F0, 8'h03);
		cfg_chk(24'h32315A);
		rd(12'h3F0, 8'h05);
		wr(12'h3F0, 8'h04);
		rd(12'h3F0, 8'h00);
		wr(12'h334, 8'h05);
		wr(12'h335, 8'h05);
		wr(12'h338, 8'hF0);
		for (int b = 0; b < 6; b++) wr(12'h33D + b[11:0], 8'h11 * (b[7:0] + 8'h01));
		rd(12'h342, 8'h66);
		nco_channel_i <= 4'h5;
		cfg_chk(24'hF05150);
		@(posedge clock_i);
		check(phase_o, 48'h665544332211);
		sample_en_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		p1 = phase_o;
		@(posedge clock_i);
		p1 = phase_o - p1;
		check(p1, 48'hFFFFFFF05150);
		sample_en_i <= 1'b0;
		wrap_up();
	end
endmodule
